// ==== ptc_pkg.sv ====
// Package: register map, field layout and constants of the periodic tick counter
package ptc_pkg;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [11:0] PTC_OFS_CTRL  = 12'h000;
  localparam logic [11:0] PTC_OFS_COUNT = 12'h004;
  localparam logic [11:0] PTC_OFS_MOD   = 12'h008;

  // ------------------------------------------------------------
  // Control, count and modulo register field positions
  // ------------------------------------------------------------
  localparam int PTC_PS_LSB   = 0;
  localparam int PTC_PS_MSB   = 3;
  localparam int PTC_PSEL_BIT = 4;
  localparam int PTC_CLKS_LSB = 5;
  localparam int PTC_CLKS_MSB = 6;
  localparam int PTC_IE_BIT   = 7;
  localparam int PTC_FLAG_BIT = 8;
  localparam int PTC_VAL_LSB  = 0;
  localparam int PTC_VAL_MSB  = 7;

  // ------------------------------------------------------------
  // Reset values and encodings
  // ------------------------------------------------------------
  localparam logic [7:0] PTC_COUNT_RST = 8'h00;
  localparam logic [7:0] PTC_MOD_RST   = 8'h00;
  localparam logic [3:0] PTC_PS_OFF    = 4'h0;
  localparam logic [1:0] PTC_SRC_LPO   = 2'h0;
  localparam logic [1:0] PTC_SRC_EXT   = 2'h1;
  localparam logic [1:0] PTC_SRC_INT   = 2'h2;
  localparam logic [1:0] PTC_SRC_BAD   = 2'h3;
  localparam logic [7:0] PTC_COUNT_STEP = 8'h01;
  localparam logic [0:0] PTC_PSEL_BIN  = 1'h0;
  localparam logic [0:0] PTC_PSEL_DEC  = 1'h1;

  // Control fields carried together
  typedef struct packed {
    logic       irq_en;
    logic [1:0] clock_source_select;
    logic       dec_mode;
    logic [3:0] prescale_select;
  } ptc_ctrl_t;

  localparam ptc_ctrl_t PTC_CTRL_RST = '{irq_en: 1'h0, clock_source_select: PTC_SRC_LPO,
                                         dec_mode: 1'h0, prescale_select: PTC_PS_OFF};

endpackage

// ==== ptc_sync.sv ====
// Two-flop level synchroniser for the clock source pins
`timescale 1ns/100ps
module ptc_sync
  import ptc_pkg::*;
(
  input  wire logic CLK_IN,
  input  wire logic RST_N_IN,
  input  wire logic d_in,
  output logic      q_out
);
  logic meta;

  // ------------------------------------------------------------
  // Synchroniser stages
  // ------------------------------------------------------------
  // First stage feeds only the second
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      meta  <= 1'b0;
      q_out <= 1'b0;
    end else begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule

// ==== ptc_prescaler.sv ====
// Prescaler: binary or decimal division of source edges into one-cycle ticks
`timescale 1ns/100ps
module ptc_prescaler
  import ptc_pkg::*;
#(
  parameter int CW = 20
) (
  input  wire logic       CLK_IN,
  input  wire logic       RST_N_IN,
  input  wire logic       src_edge_in,
  input  wire logic       clear_in,
  input  wire logic       dec_mode_in,
  input  wire logic [3:0] sel_in,
  output logic            tick_out
);
  logic [CW-1:0] cnt;
  logic [CW-1:0] limit;

  // ------------------------------------------------------------
  // Division limit
  // ------------------------------------------------------------
  // Binary: 2^(sel-1); decimal: 1-2-5 table from 1 at code 1 up to 50000 at code F
  always_comb begin
    limit = '0;
    if (!dec_mode_in) begin
      limit = CW'(1) << (sel_in - 4'h1);
    end else begin
      case (sel_in)
        4'h1:    limit = CW'(1);
        4'h2:    limit = CW'(2);
        4'h3:    limit = CW'(5);
        4'h4:    limit = CW'(10);
        4'h5:    limit = CW'(20);
        4'h6:    limit = CW'(50);
        4'h7:    limit = CW'(100);
        4'h8:    limit = CW'(200);
        4'h9:    limit = CW'(500);
        4'hA:    limit = CW'(1000);
        4'hB:    limit = CW'(2000);
        4'hC:    limit = CW'(5000);
        4'hD:    limit = CW'(10000);
        4'hE:    limit = CW'(20000);
        default: limit = CW'(50000);
      endcase
    end
  end

  // ------------------------------------------------------------
  // Division counter
  // ------------------------------------------------------------
  // Off while selection is zero, cleared on request
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cnt      <= '0;
      tick_out <= 1'b0;
    end else if (clear_in || sel_in == PTC_PS_OFF) begin
      cnt      <= '0;
      tick_out <= 1'b0;
    end else if (src_edge_in) begin
      if (cnt + CW'(1) >= limit) begin
        cnt      <= '0;
        tick_out <= 1'b1;
      end else begin
        cnt      <= cnt + CW'(1);
        tick_out <= 1'b0;
      end
    end else begin
      tick_out <= 1'b0;
    end
  end
endmodule

// ==== ptc_top.sv ====
// Periodic tick counter: APB registers, source select, prescaler and 8-bit modulo counter
// Function
// - Count register is read-only, writes ignored
// - Changed prescale selection clears the count
// - Count match modulo: restart, set flag
// - Modulo zero flags every prescaler tick
// - Modulo write clears prescaler and count
// - Reset loads modulo with zero
// - Counter, modulo, selector, binary/decimal prescaler
// - Reset: counter stopped at zero, prescaler off
// - Reset selects low-power oscillator source
// - Prescaler off while selection is zero
// - Source select picks one of three
// - Changed source selection clears prescaler, count
// - Software-enabled interrupt from tick flag
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module ptc_top
  import ptc_pkg::*;
#(
  parameter int PS_WIDTH = 20
) (
  input  wire logic        CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  input  wire logic [3:0]  PSTRB_IN,
  output logic [31:0]      PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic        LPO_CLK_IN,
  input  wire logic        EXT_REF_CLK_IN,
  input  wire logic        INT_REF_CLK_IN,
  output logic             IRQ_OUT
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  ptc_ctrl_t  ctrl;
  logic [7:0] tick_count_value;
  logic [7:0] tick_modulo_value;
  logic       tick_flag;
  logic       lpo_s;
  logic       ext_s;
  logic       int_s;
  logic       src_lvl;
  logic       src_prev;
  logic       src_edge;
  logic       ps_tick;
  logic       clear_all;
  logic       wr_en;
  logic       rd_en;
  logic       hit_ctrl;
  logic       hit_count;
  logic       hit_mod;
  logic       mapped;
  logic       wr_ctrl;
  logic       wr_mod;
  logic       flag_clr;
  logic       match;
  ptc_ctrl_t  next_ctrl;
  logic [31:0] next_rdata;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  // Zero-wait slave; unmapped address gives PSLVERR
  assign wr_en     = PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign rd_en     = PSEL_IN && !PWRITE_IN;
  assign hit_ctrl  = PADDR_IN == PTC_OFS_CTRL;
  assign hit_count = PADDR_IN == PTC_OFS_COUNT;
  assign hit_mod   = PADDR_IN == PTC_OFS_MOD;
  assign mapped    = hit_ctrl || hit_count || hit_mod;
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !mapped;
  assign wr_ctrl   = wr_en && hit_ctrl;
  assign wr_mod    = wr_en && hit_mod && PSTRB_IN[0];

  // Control write merges byte lanes with current value
  always_comb begin
    next_ctrl = ctrl;
    if (PSTRB_IN[0]) begin
      next_ctrl.prescale_select     = PWDATA_IN[PTC_PS_MSB:PTC_PS_LSB];
      next_ctrl.dec_mode            = PWDATA_IN[PTC_PSEL_BIT];
      next_ctrl.clock_source_select = PWDATA_IN[PTC_CLKS_MSB:PTC_CLKS_LSB];
      next_ctrl.irq_en              = PWDATA_IN[PTC_IE_BIT];
    end
    if (next_ctrl.clock_source_select == PTC_SRC_BAD) begin
      next_ctrl.clock_source_select = ctrl.clock_source_select;
    end
  end

  // Write-one-to-clear of the tick flag
  assign flag_clr = wr_ctrl && PSTRB_IN[1] && PWDATA_IN[PTC_FLAG_BIT];

  // Changed prescale or source, or modulo write, clears prescaler and count
  assign clear_all = wr_mod
                  || (wr_ctrl && (next_ctrl.prescale_select != ctrl.prescale_select
                               || next_ctrl.dec_mode != ctrl.dec_mode))
                  || (wr_ctrl && next_ctrl.clock_source_select != ctrl.clock_source_select);

  // ------------------------------------------------------------
  // Control and modulo registers
  // ------------------------------------------------------------
  // Reset: prescaler off, low-power source, irq disabled
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ctrl <= PTC_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= next_ctrl;
    end
  end

  // Modulo register, zero after reset
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      tick_modulo_value <= PTC_MOD_RST;
    end else if (wr_mod) begin
      tick_modulo_value <= PWDATA_IN[PTC_VAL_MSB:PTC_VAL_LSB];
    end
  end

  // ------------------------------------------------------------
  // Clock source selection
  // ------------------------------------------------------------
  ptc_sync u_sync_lpo (
    .CLK_IN   (CLK_IN),
    .RST_N_IN (RST_N_IN),
    .d_in     (LPO_CLK_IN),
    .q_out    (lpo_s)
  );
  ptc_sync u_sync_ext (
    .CLK_IN   (CLK_IN),
    .RST_N_IN (RST_N_IN),
    .d_in     (EXT_REF_CLK_IN),
    .q_out    (ext_s)
  );
  ptc_sync u_sync_int (
    .CLK_IN   (CLK_IN),
    .RST_N_IN (RST_N_IN),
    .d_in     (INT_REF_CLK_IN),
    .q_out    (int_s)
  );

  // Three-way source mux
  always_comb begin
    case (ctrl.clock_source_select)
      PTC_SRC_EXT: src_lvl = ext_s;
      PTC_SRC_INT: src_lvl = int_s;
      default:     src_lvl = lpo_s;
    endcase
  end

  // Rising-edge detect on selected source
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      src_prev <= 1'b0;
    end else begin
      src_prev <= src_lvl;
    end
  end
  assign src_edge = src_lvl && !src_prev;

  // ------------------------------------------------------------
  // Prescaler
  // ------------------------------------------------------------
  // Binary or decimal division, off at selection zero
  ptc_prescaler #(
    .CW (PS_WIDTH)
  ) u_presc (
    .CLK_IN      (CLK_IN),
    .RST_N_IN    (RST_N_IN),
    .src_edge_in (src_edge),
    .clear_in    (clear_all),
    .dec_mode_in (ctrl.dec_mode),
    .sel_in      (ctrl.prescale_select),
    .tick_out    (ps_tick)
  );

  // ------------------------------------------------------------
  // Modulo counter and tick flag
  // ------------------------------------------------------------
  assign match = tick_count_value == tick_modulo_value;

  // Count up per prescaler tick, restart on match
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      tick_count_value <= PTC_COUNT_RST;
    end else if (clear_all) begin
      tick_count_value <= PTC_COUNT_RST;
    end else if (ps_tick) begin
      if (match) begin
        tick_count_value <= PTC_COUNT_RST;
      end else begin
        tick_count_value <= tick_count_value + PTC_COUNT_STEP;
      end
    end
  end

  // Sticky flag, set beats clear
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      tick_flag <= 1'b0;
    end else if (ps_tick && match && !clear_all) begin
      tick_flag <= 1'b1;
    end else if (flag_clr) begin
      tick_flag <= 1'b0;
    end
  end

  // Interrupt request gated by enable
  assign IRQ_OUT = tick_flag && ctrl.irq_en;

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  // Count register is read-only
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_ctrl) begin
      next_rdata[PTC_PS_MSB:PTC_PS_LSB]     = ctrl.prescale_select;
      next_rdata[PTC_PSEL_BIT]              = ctrl.dec_mode;
      next_rdata[PTC_CLKS_MSB:PTC_CLKS_LSB] = ctrl.clock_source_select;
      next_rdata[PTC_IE_BIT]                = ctrl.irq_en;
      next_rdata[PTC_FLAG_BIT]              = tick_flag;
    end else if (hit_count) begin
      next_rdata[PTC_VAL_MSB:PTC_VAL_LSB] = tick_count_value;
    end else if (hit_mod) begin
      next_rdata[PTC_VAL_MSB:PTC_VAL_LSB] = tick_modulo_value;
    end
  end

  // Registered read data, captured in setup phase
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      PRDATA_OUT <= 32'h0000_0000;
    end else if (rd_en && !PENABLE_IN) begin
      PRDATA_OUT <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_tick_match;
    ps_tick && match && !clear_all;
  endsequence

  chk_count_readonly: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (wr_en && hit_count && !clear_all && !ps_tick) |=> $stable(tick_count_value))
    else $error("count changed by write");
  chk_clear_on_mod: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    wr_mod |=> (tick_count_value == 8'h00 && !ps_tick))
    else $error("modulo write did not clear");
  chk_clear_on_ps: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (wr_ctrl && next_ctrl.prescale_select != ctrl.prescale_select) |=> tick_count_value == 8'h00)
    else $error("prescale change did not clear");
  chk_clear_on_src: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (wr_ctrl && next_ctrl.clock_source_select != ctrl.clock_source_select) |=> tick_count_value == 8'h00)
    else $error("source change did not clear");
  chk_match_restart: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    s_tick_match |=> (tick_count_value == 8'h00 && tick_flag))
    else $error("match did not restart");
  chk_mod_zero_flag: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (ps_tick && tick_modulo_value == 8'h00 && !clear_all) |=> tick_flag)
    else $error("zero modulo missed flag");
  chk_ps_off_hold: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (ctrl.prescale_select == PTC_PS_OFF && !clear_all) [*2] |-> $stable(tick_count_value))
    else $error("count moved while off");
  chk_count_incr: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (ps_tick && !match && !clear_all) |=> tick_count_value == $past(tick_count_value) + 8'h01)
    else $error("count did not increment");
  chk_flag_sticky: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (tick_flag && !flag_clr) |=> tick_flag)
    else $error("flag dropped without clear");
  // Flag set by a match raises the request when enabled
  chk_irq_gate: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (s_tick_match ##0 (ctrl.irq_en && !wr_ctrl)) |=> IRQ_OUT)
    else $error("irq not raised by flag");

  // ------------------------------------------------------------
  // Assertions: reset state, registers and pulses
  // ------------------------------------------------------------
  // Reset held over two edges, so every flop has settled
  sequence s_held_reset;
    !RST_N_IN ##1 !RST_N_IN;
  endsequence

  // Counter stopped at zero, flag clear, prescaler quiet
  chk_reset_state: assert property (@(posedge CLK_IN)
    s_held_reset |-> (tick_count_value == PTC_COUNT_RST && !tick_flag && !ps_tick))
    else $error("reset left counter state");
  // Low-power oscillator chosen, prescaler off
  chk_reset_source: assert property (@(posedge CLK_IN)
    s_held_reset |-> (ctrl.clock_source_select == PTC_SRC_LPO && ctrl.prescale_select == PTC_PS_OFF))
    else $error("reset left source or prescale");
  // Modulo register zero during reset
  chk_reset_modulo: assert property (@(posedge CLK_IN)
    s_held_reset |-> tick_modulo_value == PTC_MOD_RST)
    else $error("reset left modulo");
  // Modulo takes the written low byte
  chk_mod_load: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    wr_mod |=> tick_modulo_value == $past(PWDATA_IN[PTC_VAL_MSB:PTC_VAL_LSB]))
    else $error("modulo write not loaded");
  // Modulo changes only on its own write
  chk_mod_hold: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    !wr_mod |=> $stable(tick_modulo_value))
    else $error("modulo changed without write");
  // Reserved source code keeps the old source
  chk_src_code_kept: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (wr_ctrl && PSTRB_IN[0] && PWDATA_IN[PTC_CLKS_MSB:PTC_CLKS_LSB] == PTC_SRC_BAD)
      |=> $stable(ctrl.clock_source_select))
    else $error("reserved source code taken");
  // No prescaler tick while selection is zero
  chk_ps_off_quiet: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (ctrl.prescale_select == PTC_PS_OFF) |=> !ps_tick)
    else $error("tick while prescaler off");
  // Prescaler tick lasts one cycle
  chk_tick_pulse: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    ps_tick |=> !ps_tick)
    else $error("tick longer than one cycle");
  // Count holds between ticks
  chk_count_hold: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (!ps_tick && !clear_all) |=> $stable(tick_count_value))
    else $error("count moved without tick");
  // Flag only set by a match
  chk_flag_no_set: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (!tick_flag && !(ps_tick && match && !clear_all)) |=> !tick_flag)
    else $error("flag set without match");
  // Clear without a match drops the flag
  chk_flag_clear: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (flag_clr && !(ps_tick && match && !clear_all)) |=> !tick_flag)
    else $error("flag clear ignored");
  // Request falls with the flag clear
  chk_irq_clear: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (flag_clr && !ps_tick) |=> !IRQ_OUT)
    else $error("irq stayed after clear");
endmodule

// ==== ptc_tb.sv ====
// Self-checking testbench of the periodic tick counter
`timescale 1ns/100ps
module testbench;
  import ptc_pkg::*;

  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  src;
  logic        irq;
  int          bad_count;
  int          n_checks;

  ptc_top #(.PS_WIDTH(20)) i_ptc_top (
    .CLK_IN         (clk),
    .RST_N_IN       (rst_n),
    .PSEL_IN        (psel),
    .PENABLE_IN     (penable),
    .PWRITE_IN      (pwrite),
    .PADDR_IN       (paddr),
    .PWDATA_IN      (pwdata),
    .PSTRB_IN       (pstrb),
    .PRDATA_OUT     (prdata),
    .PREADY_OUT     (pready),
    .PSLVERR_OUT    (pslverr),
    .LPO_CLK_IN     (src[0]),
    .EXT_REF_CLK_IN (src[1]),
    .INT_REF_CLK_IN (src[2]),
    .IRQ_OUT        (irq)
  );

  // ----------------------------------------
  // Clock, reset and initial input values
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
    src = 3'h0;
    bad_count = 0;
    n_checks = 0;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer, then one idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'h1);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, s, rd, er);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h00000000, 4'h0, rd, er);
    chk(rd, exp);
  endtask

  // One rising edge on a source clock, slow against CLK
  task automatic pulse(input int i);
    src[i] <= 1'b1;
    repeat (4) @(posedge clk);
    src[i] <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rdchk(PTC_OFS_CTRL, 32'h00000000);
    rdchk(PTC_OFS_COUNT, 32'h00000000);
    rdchk(PTC_OFS_MOD, 32'h00000000);
    chk({31'h0, irq}, 32'h00000000);
    pulse(0);
    pulse(0);
    rdchk(PTC_OFS_COUNT, 32'h00000000);
  endtask

  task automatic t_count_ro();
    logic [31:0] rd;
    logic        er;
    wr(PTC_OFS_MOD, 32'h000000FF);
    wr(PTC_OFS_CTRL, 32'h00000001);
    repeat (3) pulse(0);
    rdchk(PTC_OFS_COUNT, 32'h00000003);
    wr(PTC_OFS_COUNT, 32'h00000055);
    rdchk(PTC_OFS_COUNT, 32'h00000003);
    apb(1'b1, 12'h00C, 32'h00000000, 4'hF, rd, er);
    chk({31'h0, er}, 32'h00000001);
    rdchk(PTC_OFS_COUNT, 32'h00000003);
  endtask

  // Each source counts alone; a changed source clears the count
  task automatic t_src();
    for (int i = 0; i < 3; i++) begin
      wr(PTC_OFS_CTRL, 32'h00000001 | (i << 5));
      rdchk(PTC_OFS_COUNT, (i == 0) ? 32'h00000003 : 32'h00000000);
      pulse((i + 1) % 3);
      rdchk(PTC_OFS_COUNT, (i == 0) ? 32'h00000003 : 32'h00000000);
      pulse(i);
      rdchk(PTC_OFS_COUNT, (i == 0) ? 32'h00000004 : 32'h00000001);
    end
    wr(PTC_OFS_CTRL, 32'h00000061);
    rdchk(PTC_OFS_CTRL, 32'h00000041);
    wr(PTC_OFS_CTRL, 32'h00000001);
    rdchk(PTC_OFS_COUNT, 32'h00000000);
  endtask

  task automatic t_ps();
    pulse(0);
    pulse(0);
    wr(PTC_OFS_CTRL, 32'h00000001);
    rdchk(PTC_OFS_COUNT, 32'h00000002);
    wr(PTC_OFS_CTRL, 32'h00000002);
    rdchk(PTC_OFS_COUNT, 32'h00000000);
    repeat (4) pulse(0);
    rdchk(PTC_OFS_COUNT, 32'h00000002);
    wr(PTC_OFS_CTRL, 32'h00000011);
    rdchk(PTC_OFS_COUNT, 32'h00000000);
    pulse(0);
    rdchk(PTC_OFS_COUNT, 32'h00000001);
    wr(PTC_OFS_CTRL, 32'h00000013);
    repeat (4) pulse(0);
    rdchk(PTC_OFS_COUNT, 32'h00000000);
    pulse(0);
    rdchk(PTC_OFS_COUNT, 32'h00000001);
  endtask

  task automatic t_mod();
    wr(PTC_OFS_CTRL, 32'h00000001);
    wr(PTC_OFS_MOD, 32'h00000002);
    pulse(0);
    pulse(0);
    rdchk(PTC_OFS_COUNT, 32'h00000002);
    rdchk(PTC_OFS_CTRL, 32'h00000001);
    pulse(0);
    rdchk(PTC_OFS_COUNT, 32'h00000000);
    rdchk(PTC_OFS_CTRL, 32'h00000101);
    chk({31'h0, irq}, 32'h00000000);
    wr(PTC_OFS_CTRL, 32'h00000081);
    chk({31'h0, irq}, 32'h00000001);
    pulse(0);
    rdchk(PTC_OFS_CTRL, 32'h00000181);
    wr(PTC_OFS_CTRL, 32'h00000181, 4'h3);
    chk({31'h0, irq}, 32'h00000000);
    rdchk(PTC_OFS_CTRL, 32'h00000081);
    rdchk(PTC_OFS_COUNT, 32'h00000001);
    wr(PTC_OFS_MOD, 32'h00000005);
    rdchk(PTC_OFS_COUNT, 32'h00000000);
    rdchk(PTC_OFS_MOD, 32'h00000005);
  endtask

  task automatic t_mod0();
    wr(PTC_OFS_MOD, 32'h00000000);
    for (int k = 0; k < 2; k++) begin
      pulse(0);
      rdchk(PTC_OFS_COUNT, 32'h00000000);
      rdchk(PTC_OFS_CTRL, 32'h00000181);
      chk({31'h0, irq}, 32'h00000001);
      wr(PTC_OFS_CTRL, 32'h00000181, 4'h3);
      rdchk(PTC_OFS_CTRL, 32'h00000081);
    end
  endtask

  // Mid-run reset returns every register to its reset value
  task automatic t_rst_mid();
    wr(PTC_OFS_MOD, 32'h00000001);
    repeat (3) pulse(0);
    rdchk(PTC_OFS_COUNT, 32'h00000001);
    rdchk(PTC_OFS_CTRL, 32'h00000181);
    chk({31'h0, irq}, 32'h00000001);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdchk(PTC_OFS_CTRL, 32'h00000000);
    rdchk(PTC_OFS_COUNT, 32'h00000000);
    rdchk(PTC_OFS_MOD, 32'h00000000);
    chk({31'h0, irq}, 32'h00000000);
    pulse(0);
    rdchk(PTC_OFS_COUNT, 32'h00000000);
  endtask

  // ----------------------------------------
  // Closing, watchdog and main sequence
  // ----------------------------------------
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    test_done();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_count_ro();
    t_src();
    t_ps();
    t_mod();
    t_mod0();
    t_rst_mid();
    test_done();
  end
endmodule
